/* scap_pkg.sv */
// constants and types shared by the command and address port
package scap_pkg;

   // ****************************************
   // geometry
   // ****************************************
   localparam int NUM_BANKS = 8;
   localparam int BANK_W    = 3;
   localparam int ADDR_W    = 13;
   localparam int COL_W     = 10;
   localparam int DQ_W      = 8;
   localparam int MR_COUNT  = 4;
   localparam int AP_BIT    = 10;
   localparam int CHOP_BIT  = 12;

   // ****************************************
   // mode register fields
   // ****************************************
   localparam int MR0_BL_LSB = 0;
   localparam int MR0_BT_BIT = 3;
   localparam int MR0_CL_LSB = 4;
   localparam int MR1_AL_LSB = 3;
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF    = 2'h1;
   localparam logic [1:0] BL_FIXED4 = 2'h2;
   localparam logic [1:0] AL_CL1    = 2'h1;
   localparam logic [1:0] AL_CL2    = 2'h2;
   localparam logic [4:0] CL_BASE   = 5'h04;
   localparam logic [ADDR_W-1:0] MR_RESET = 13'h0000;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_PS   = 25000;
   localparam int REFI_NORMAL_NS  = 7800;
   localparam int REFI_EXT_NS     = 3900;
   // average intervals are upper bounds, so they round down
   localparam int REFI_NORMAL_CYC = (REFI_NORMAL_NS * 1000) / CLK_PERIOD_PS;
   localparam int REFI_EXT_CYC    = (REFI_EXT_NS * 1000) / CLK_PERIOD_PS;
   localparam int REF_CNT_W       = 10;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      CMD_NOP, CMD_ROW_OPEN, CMD_READ, CMD_WRITE,
      CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_SET
   } scap_cmd_t;

   typedef enum logic [1:0] {PWR_ACTIVE, PWR_SUSPEND, PWR_POWERDOWN, PWR_SELFREF} scap_pwr_t;

   typedef enum logic [1:0] {XF_IDLE, XF_RD_WAIT, XF_RD_BURST, XF_WR_BURST} scap_xfer_t;

endpackage : scap_pkg

/* scap_burst_if.sv */
// burst sequencing signals between the port and its column sequencer
`timescale 1ns/10ps
interface scap_burst_if;
   logic       start;
   logic       chop;
   logic       interleave;
   logic       step;
   logic [2:0] startCol;
   logic [2:0] col;
   logic       last;
   logic       busy;

   modport ctl (output start, chop, interleave, step, startCol, input col, last, busy);
   modport seq (input start, chop, interleave, step, startCol, output col, last, busy);
endinterface : scap_burst_if

/* scap_burst_seq.sv */
// column order generator for one read or write burst
`timescale 1ns/10ps
module scap_burst_seq
   import scap_pkg::*;
(
   input wire logic   clock,
   input wire logic   reset,
   scap_burst_if.seq  bus
);

   logic [2:0] beat_r;
   logic [2:0] base_r;
   logic       chop_r;
   logic       ilv_r;
   logic       busy_r;
   logic [2:0] lastBeat;
   logic [2:0] seqCol;
   logic [2:0] ilvCol;

   // ****************************************
   // column order
   // ****************************************
   // a chopped burst wraps inside its group of four
   assign lastBeat = chop_r ? 3'h3 : 3'h7;
   assign seqCol   = chop_r ? {base_r[2], 2'(base_r[1:0] + beat_r[1:0])}
                            : 3'(base_r + beat_r);
   assign ilvCol   = base_r ^ beat_r;
   assign bus.col  = ilv_r ? ilvCol : seqCol;
   assign bus.last = busy_r && (beat_r == lastBeat);
   assign bus.busy = busy_r;

   // beat counter, a new start overrides any leftover burst
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         beat_r <= 3'h0;
         base_r <= 3'h0;
         chop_r <= 1'b0;
         ilv_r  <= 1'b0;
         busy_r <= 1'b0;
      end
      else if (bus.start)
      begin
         beat_r <= 3'h0;
         base_r <= bus.startCol;
         chop_r <= bus.chop;
         ilv_r  <= bus.interleave;
         busy_r <= 1'b1;
      end
      else if (bus.step && busy_r)
      begin
         beat_r <= 3'(beat_r + 3'h1);
         busy_r <= !bus.last;
      end
   end

endmodule : scap_burst_seq

/* scap_cmd_port.sv */
// command, address and clocking front end of an eight-bank ddr memory
//
// Notes on behaviour
// - inputs are taken where true clock rises and complement clock falls
// - read beats leave on clock crossings of both directions, two per period
// - clock gate sampled low halts internal clock from next cycle, freezing state
// - gate dropped with all banks idle enters power-down or self-refresh
// - three-bit bank select picks the bank for open, read, write, precharge
// - row open takes thirteen row bits; read and write take ten column bits
// - mode register set loads the address bus into the selected mode register
// - burst length is four or eight beats
// - burst column order is sequential or interleaved
// - additive latency is zero, read latency minus one or minus two
// - eight independent banks may each hold a row open
// - data is timed by the strobe pair driven by whoever sends it
// - address bit ten: auto-precharge on access, all banks on precharge
// - in on-the-fly burst length mode, address bit twelve low chops the burst, high keeps it full
// - chip select sampled high masks every command
// - strobe patterns decode to row open, precharge, read and write
`timescale 1ns/10ps
module scap_cmd_port
   import scap_pkg::*;
#(
   parameter int DQ_WIDTH = DQ_W
)
(
   input  wire logic                  clock,
   input  wire logic                  reset,
   input  wire logic                  ckTrue,
   input  wire logic                  ckComp,
   input  wire logic                  clockGate,
   input  wire logic                  chipSelN,
   input  wire logic                  rowStrobeN,
   input  wire logic                  colStrobeN,
   input  wire logic                  writeEnN,
   input  wire logic [BANK_W-1:0]     bankSelect,
   input  wire logic [ADDR_W-1:0]     addressBus,
   input  wire logic [DQ_WIDTH-1:0]   dqIn,
   input  wire logic                  dqsIn,
   input  wire logic                  dqsNIn,
   input  wire logic                  extTemp,
   input  wire logic [DQ_WIDTH-1:0]   arrayRdData,
   output logic      [DQ_WIDTH-1:0]   dqOut_r,
   output logic                       dqOe_r,
   output logic                       dqsOut_r,
   output logic                       dqsNOut_r,
   output logic                       dqsOe_r,
   output logic                       accValid_r,
   output logic                       accWrite_r,
   output logic      [BANK_W-1:0]     accBank_r,
   output logic      [ADDR_W-1:0]     accRow_r,
   output logic      [COL_W-1:0]      accCol_r,
   output logic      [DQ_WIDTH-1:0]   accData_r,
   output logic      [NUM_BANKS-1:0]  bankOpen_r,
   output logic                       powerDown_r,
   output logic                       selfRefresh_r,
   output logic                       clockHalted_r,
   output logic                       refreshLate_r
);

   localparam int PIN_W = 10 + BANK_W + ADDR_W + DQ_WIDTH; // ten single pins plus buses

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [PIN_W-1:0] pinRaw;
   logic [PIN_W-1:0] pinMeta_r;
   logic [PIN_W-1:0] pinSync_r;
   logic [PIN_W-1:0] pinPrev_r;
   logic ckT, ckC, cke, csN, rasN, casN, weN, dqsS, dqsNS, hot, ckTPrev;
   logic dqsPrev, dqsNPrev;
   logic [BANK_W-1:0]   bankS;
   logic [ADDR_W-1:0]   addrS;
   logic [DQ_WIDTH-1:0] dqS;

   assign pinRaw = {ckTrue, ckComp, clockGate, chipSelN, rowStrobeN, colStrobeN,
                    writeEnN, bankSelect, addressBus, dqIn, dqsIn, dqsNIn, extTemp};
   assign {ckT, ckC, cke, csN, rasN, casN, weN, bankS, addrS, dqS, dqsS, dqsNS, hot}
          = pinSync_r;
   assign ckTPrev  = pinPrev_r[PIN_W-1];
   assign dqsPrev  = pinPrev_r[2];
   assign dqsNPrev = pinPrev_r[1];

   // every pin goes through the same two stages so they stay aligned
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         pinMeta_r <= '0;
         pinSync_r <= '0;
         pinPrev_r <= '0;
      end
      else
      begin
         pinMeta_r <= pinRaw;
         pinSync_r <= pinMeta_r;
         pinPrev_r <= pinSync_r;
      end
   end

   // ****************************************
   // clock crossings and gating
   // ****************************************
   logic ckRise, ckEdge, dqsEdge, tick, ckeSampled_r;

   assign ckRise  = ckT && !ckTPrev && !ckC;
   assign ckEdge  = ckT != ckTPrev;
   assign dqsEdge = (dqsS && !dqsNS) != (dqsPrev && !dqsNPrev);
   // the gate level taken at one crossing governs the next one
   assign tick    = ckRise && ckeSampled_r;

   // gate sample; starts low so nothing runs until the controller raises it
   always_ff @(posedge clock)
   begin
      if (reset)
         ckeSampled_r <= 1'b0;
      else if (ckRise)
         ckeSampled_r <= cke;
   end

   // ****************************************
   // command decode
   // ****************************************
   scap_cmd_t cmd;
   logic      cmdValid;

   function automatic scap_cmd_t decodeCmd(input logic r, input logic c, input logic w);
      scap_cmd_t res;
      res = CMD_NOP;
      unique case ({r, c, w})
         3'b011:  res = CMD_ROW_OPEN;
         3'b010:  res = CMD_PRECHARGE;
         3'b101:  res = CMD_READ;
         3'b100:  res = CMD_WRITE;
         3'b001:  res = CMD_REFRESH;
         3'b000:  res = CMD_MODE_SET;
         default: res = CMD_NOP;
      endcase
      return res;
   endfunction : decodeCmd

   assign cmd      = decodeCmd(rasN, casN, weN);
   assign cmdValid = tick && !csN;

   // ****************************************
   // mode registers
   // ****************************************
   logic [ADDR_W-1:0] modeReg_r [MR_COUNT];
   logic [1:0]        blField, alField;
   logic [4:0]        readLat, addLat, totalLat;
   logic              interleave;

   // mr0 holds burst and read latency, mr1 the additive latency
   assign blField    = modeReg_r[0][MR0_BL_LSB +: 2];
   assign interleave = modeReg_r[0][MR0_BT_BIT];
   assign readLat    = 5'(CL_BASE + 5'(modeReg_r[0][MR0_CL_LSB +: 3]));
   assign alField    = modeReg_r[1][MR1_AL_LSB +: 2];
   assign addLat     = (alField == AL_CL1) ? 5'(readLat - 5'h01) :
                       (alField == AL_CL2) ? 5'(readLat - 5'h02) : 5'h00;
   assign totalLat   = 5'(readLat + addLat);

   // the top bank bit must be clear; other selections are dropped
   always_ff @(posedge clock)
   begin
      if (reset)
         modeReg_r <= '{default: MR_RESET};
      else if (cmdValid && cmd == CMD_MODE_SET && !bankS[2])
         modeReg_r[bankS[1:0]] <= addrS;
   end

   // ****************************************
   // bank state
   // ****************************************
   logic [ADDR_W-1:0] bankRow_r [NUM_BANKS];
   logic              apClose;
   logic              allIdle;

   assign allIdle = (bankOpen_r == '0);

   genvar gb;
   generate
      for (gb = 0; gb < NUM_BANKS; gb++)
      begin : g_bank
         logic hit, openIt, closeIt;
         assign hit     = bankS == BANK_W'(gb);
         assign openIt  = cmdValid && cmd == CMD_ROW_OPEN && hit;
         assign closeIt = (cmdValid && cmd == CMD_PRECHARGE && (addrS[AP_BIT] || hit))
                          || (apClose && accBank_r == BANK_W'(gb));
         // each bank keeps its own row, so all eight may be open together
         always_ff @(posedge clock)
         begin
            if (reset)
            begin
               bankOpen_r[gb] <= 1'b0;
               bankRow_r[gb]  <= '0;
            end
            else if (openIt)
            begin
               bankOpen_r[gb] <= 1'b1;
               bankRow_r[gb]  <= addrS;
            end
            else if (closeIt)
               bankOpen_r[gb] <= 1'b0;
         end
      end
   endgenerate

   // ****************************************
   // power state
   // ****************************************
   scap_pwr_t pwr_r, pwrNxt;
   logic      gateDrop;

   assign gateDrop = ckRise && ckeSampled_r && !cke;
   // low power only with every bank idle, otherwise a plain clock suspend
   assign pwrNxt = (ckRise && cke) ? PWR_ACTIVE :
                   !gateDrop ? pwr_r :
                   !allIdle ? PWR_SUSPEND :
                   (!csN && cmd == CMD_REFRESH) ? PWR_SELFREF : PWR_POWERDOWN;

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         pwr_r         <= PWR_SUSPEND;
         powerDown_r   <= 1'b0;
         selfRefresh_r <= 1'b0;
         clockHalted_r <= 1'b1;
      end
      else
      begin
         pwr_r         <= pwrNxt;
         powerDown_r   <= pwrNxt == PWR_POWERDOWN;
         selfRefresh_r <= pwrNxt == PWR_SELFREF;
         clockHalted_r <= pwrNxt != PWR_ACTIVE;
      end
   end

   // ****************************************
   // burst transfer
   // ****************************************
   scap_burst_if bus ();
   scap_xfer_t   xfer_r;
   logic [4:0]   latCnt_r;
   logic [6:0]   colHi_r;
   logic         apPend_r, colUpd_r;
   logic         startBurst, isRead, rdFire, rdDone, wrBeat, xferDone;

   scap_burst_seq u_seq (
      .clock (clock),
      .reset (reset),
      .bus   (bus)
   );

   // only one burst in flight; accesses to a closed bank are dropped
   assign isRead         = cmd == CMD_READ;
   assign startBurst     = cmdValid && (isRead || cmd == CMD_WRITE)
                           && xfer_r == XF_IDLE && bankOpen_r[bankS];
   assign bus.start      = startBurst;
   assign bus.startCol   = addrS[2:0];
   assign bus.interleave = interleave;
   assign bus.chop       = (blField == BL_FIXED4) ||
                           (blField == BL_OTF && !addrS[CHOP_BIT]);
   // a frozen clock freezes the burst position as well
   assign rdFire   = ((xfer_r == XF_RD_WAIT && tick && latCnt_r == 5'h01) ||
                      (xfer_r == XF_RD_BURST && ckEdge && ckeSampled_r)) && bus.busy;
   assign rdDone   = xfer_r == XF_RD_BURST && ckEdge && ckeSampled_r && !bus.busy;
   assign wrBeat   = xfer_r == XF_WR_BURST && dqsEdge && ckeSampled_r && bus.busy;
   assign bus.step = rdFire || wrBeat;
   assign xferDone = rdDone || (xfer_r == XF_WR_BURST && !bus.busy);
   assign apClose  = xferDone && apPend_r;

   // transfer state and latency count in clock crossings
   always_ff @(posedge clock)
   begin
      if (reset)
         xfer_r <= XF_IDLE;
      else
      begin
         unique case (xfer_r)
            XF_IDLE:     if (startBurst) xfer_r <= isRead ? XF_RD_WAIT : XF_WR_BURST;
            XF_RD_WAIT:  if (rdFire) xfer_r <= XF_RD_BURST;
            XF_RD_BURST: if (rdDone) xfer_r <= XF_IDLE;
            XF_WR_BURST: if (xferDone) xfer_r <= XF_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         latCnt_r   <= 5'h00;
         colHi_r    <= 7'h00;
         apPend_r   <= 1'b0;
         accBank_r  <= '0;
         accRow_r   <= '0;
         accWrite_r <= 1'b0;
      end
      else if (startBurst)
      begin
         latCnt_r   <= totalLat;
         colHi_r    <= addrS[COL_W-1:3];
         apPend_r   <= addrS[AP_BIT];
         accBank_r  <= bankS;
         accRow_r   <= bankRow_r[bankS];
         accWrite_r <= !isRead;
      end
      else if (xfer_r == XF_RD_WAIT && tick)
         latCnt_r <= 5'(latCnt_r - 5'h01);
   end

   // ****************************************
   // array side and data pins
   // ****************************************
   // the next read address is shown a beat early so the array has time
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         colUpd_r   <= 1'b0;
         accValid_r <= 1'b0;
         accCol_r   <= '0;
         accData_r  <= '0;
      end
      else
      begin
         colUpd_r   <= startBurst || bus.step;
         accValid_r <= accWrite_r ? wrBeat : (colUpd_r && bus.busy);
         if (wrBeat || colUpd_r)
            accCol_r <= {colHi_r, bus.col};
         if (wrBeat)
            accData_r <= dqS;
      end
   end

   // read beats: strobe follows the clock level at every crossing
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         dqOut_r   <= '0;
         dqOe_r    <= 1'b0;
         dqsOut_r  <= 1'b0;
         dqsNOut_r <= 1'b1;
         dqsOe_r   <= 1'b0;
      end
      else if (rdFire)
      begin
         dqOut_r   <= arrayRdData;
         dqOe_r    <= 1'b1;
         dqsOut_r  <= ckT;
         dqsNOut_r <= !ckT;
         dqsOe_r   <= 1'b1;
      end
      else if (rdDone)
      begin
         dqOe_r  <= 1'b0;
         dqsOe_r <= 1'b0;
      end
   end

   // ****************************************
   // refresh watchdog
   // ****************************************
   logic [REF_CNT_W-1:0] refGap_r;
   logic [REF_CNT_W-1:0] refLimit;
   logic                 refSeen;

   // in the hot range the controller owes twice as many refreshes
   assign refLimit = hot ? REF_CNT_W'(REFI_EXT_CYC) : REF_CNT_W'(REFI_NORMAL_CYC);
   assign refSeen  = (cmdValid && cmd == CMD_REFRESH) || pwr_r == PWR_SELFREF;

   // an average is allowed, so this flags a late refresh and does not block
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         refGap_r      <= '0;
         refreshLate_r <= 1'b0;
      end
      else if (refSeen)
      begin
         refGap_r      <= '0;
         refreshLate_r <= 1'b0;
      end
      else
      begin
         if (refGap_r != '1)
            refGap_r <= REF_CNT_W'(refGap_r + 1'b1);
         if (refGap_r >= refLimit)
            refreshLate_r <= 1'b1;
      end
   end

endmodule : scap_cmd_port

/* scap_cmd_port_asserts.sv */
// concurrent checks on the command port outputs
`timescale 1ns/10ps
module scap_cmd_port_asserts
   import scap_pkg::*;
#(
   parameter int DQ_WIDTH = DQ_W
)
(
   input wire logic                 clock,
   input wire logic                 reset,
   input wire logic                 chipSelN,
   input wire logic [NUM_BANKS-1:0] bankOpen_r,
   input wire logic [DQ_WIDTH-1:0]  dqOut_r,
   input wire logic                 dqOe_r,
   input wire logic                 dqsOut_r,
   input wire logic                 dqsNOut_r,
   input wire logic                 dqsOe_r,
   input wire logic                 accValid_r,
   input wire logic                 powerDown_r,
   input wire logic                 selfRefresh_r,
   input wire logic                 clockHalted_r
);
   // ****************
   // properties
   // ****************
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);
   // a bank only opens some clocks after chip select was seen low
   bank_cs_mask_a: assert property (
      |(bankOpen_r & ~$past(bankOpen_r)) |-> !$past(chipSelN, 3) || !$past(chipSelN, 5))
      else $error("bank opened without chip select");
   // halted clock freezes bank state and read data
   halt_freeze_a: assert property (
      clockHalted_r && $past(clockHalted_r) |-> $stable(bankOpen_r) && $stable(dqOut_r))
      else $error("state moved while halted");
   low_power_idle_a: assert property ($rose(powerDown_r) |-> bankOpen_r == '0)
      else $error("power-down with a bank open");
   low_power_halt_a: assert property (powerDown_r || selfRefresh_r |-> clockHalted_r)
      else $error("low power without halt");
   low_power_one_a: assert property (!(powerDown_r && selfRefresh_r))
      else $error("two low power states");
   data_strobe_oe_a: assert property (dqOe_r |-> dqsOe_r)
      else $error("data driven without strobe");
   strobe_pair_a: assert property (dqsOe_r |-> dqsNOut_r == !dqsOut_r)
      else $error("strobe pair not complementary");
   // first beat goes with strobe high; its data then holds for two more clocks
   first_beat_a: assert property ($rose(dqOe_r) |-> dqsOut_r ##1 $stable(dqOut_r) [*2])
      else $error("read beat timing wrong");
   acc_pulse_a: assert property (accValid_r |=> !accValid_r)
      else $error("access strobe too long");
endmodule : scap_cmd_port_asserts

bind scap_cmd_port scap_cmd_port_asserts #(.DQ_WIDTH(DQ_WIDTH)) chk_u (.clock, .reset,
   .chipSelN, .bankOpen_r, .dqOut_r, .dqOe_r, .dqsOut_r, .dqsNOut_r, .dqsOe_r,
   .accValid_r, .powerDown_r, .selfRefresh_r, .clockHalted_r);

/* scap_ctl_model.sv */
// controller model: link clock pair, clock gate and command pins
`timescale 1ns/10ps
module scap_ctl_model
   import scap_pkg::*;
(
   input wire logic           clock,
   output logic               ckTrue,
   output logic               ckComp,
   output logic               clockGate,
   output logic               chipSelN,
   output logic               rowStrobeN,
   output logic               colStrobeN,
   output logic               writeEnN,
   output logic [BANK_W-1:0]  bankSelect,
   output logic [ADDR_W-1:0]  addressBus
);
   // ****************
   // link clock and pins
   // ****************
   // free running pair, phase unrelated to the system clock
   initial
   begin
      {ckTrue, clockGate, chipSelN} = 3'h1;
      {rowStrobeN, colStrobeN, writeEnN, bankSelect, addressBus} = '1;
      #37;
      forever #100 ckTrue = ~ckTrue;
   end
   assign ckComp = ~ckTrue;
   // pins set half a period before the crossing, held half after
   task automatic send(input logic csN, input logic [2:0] rcw,
                       input logic [BANK_W-1:0] ba, input logic [ADDR_W-1:0] a);
      @(negedge ckTrue);
      @(posedge clock);
      chipSelN <= csN;
      {rowStrobeN, colStrobeN, writeEnN} <= rcw;
      bankSelect <= ba;
      addressBus <= a;
      @(negedge ckTrue);
      @(posedge clock);
      chipSelN <= 1'b1;
      bankSelect <= ~ba; // released lines never keep the old value
      addressBus <= ~a;
      repeat (3) @(posedge clock);
   endtask : send
   task automatic gate(input logic g);
      @(negedge ckTrue);
      @(posedge clock);
      clockGate <= g;
      repeat (24) @(posedge clock);
   endtask : gate
   task automatic refresh();
      send(1'b0, 3'h1, 3'h0, 13'h0000);
   endtask : refresh
endmodule : scap_ctl_model

/* tb_sdram_command_address_port.sv */
// self-checking bench for the command and address port
`timescale 1ns/10ps
module tb_sdram_command_address_port
   import scap_pkg::*;
   ;
   logic clock = 1'b0, reset = 1'b1, extTemp, dqsIn, dqsNIn;
   logic ckTrue, ckComp, clockGate, chipSelN, rowStrobeN, colStrobeN, writeEnN;
   logic [BANK_W-1:0] bankSelect, accBank_r;
   logic [ADDR_W-1:0] addressBus, accRow_r;
   logic [7:0]        dqIn, arrayRdData, dqOut_r, accData_r, bankOpen_r, expOpen;
   logic [COL_W-1:0]  accCol_r;
   logic dqOe_r, dqsOut_r, dqsNOut_r, dqsOe_r, accValid_r, accWrite_r;
   logic powerDown_r, selfRefresh_r, clockHalted_r, refreshLate_r;
   logic [31:0]       seed = 32'h299421FA;
   logic [ADDR_W-1:0] rows [NUM_BANKS];
   logic [34:0]       accQ [$];
   int                mismatches = 0;
   int                comparisons = 0;
   int                waited;
   // ****************
   // harness
   // ****************
   always #12.5 clock = ~clock;
   scap_ctl_model ctl_u (.clock, .ckTrue, .ckComp, .clockGate, .chipSelN, .rowStrobeN,
      .colStrobeN, .writeEnN, .bankSelect, .addressBus);
   scap_cmd_port dut_u (.clock, .reset, .ckTrue, .ckComp, .clockGate, .chipSelN, .rowStrobeN,
      .colStrobeN, .writeEnN, .bankSelect, .addressBus, .dqIn, .dqsIn, .dqsNIn, .extTemp,
      .arrayRdData, .dqOut_r, .dqOe_r, .dqsOut_r, .dqsNOut_r, .dqsOe_r, .accValid_r,
      .accWrite_r, .accBank_r, .accRow_r, .accCol_r, .accData_r, .bankOpen_r,
      .powerDown_r, .selfRefresh_r, .clockHalted_r, .refreshLate_r);
   // every array access the port hands on is queued for the model
   always @(posedge clock)
      if (accValid_r === 1'b1)
         accQ.push_back({accWrite_r, accBank_r, accRow_r, accCol_r, accData_r});
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // burst column: interleave xors, chopped sequential wraps within four
   function automatic logic [9:0] colOf(input logic [9:0] c, input int i,
                                        input logic il, input logic ch);
      logic [2:0] b;
      b = il ? c[2:0] ^ 3'(i) : ch ? {c[2], c[1:0] + 2'(i)} : c[2:0] + 3'(i);
      return {c[9:3], b};
   endfunction : colOf
   task automatic cmpVec(input logic [34:0] got, input logic [34:0] exp);
      #1;
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : cmpVec
   task automatic cmpAcc(input logic [34:0] exp);
      cmpVec(accQ.size() > 0 ? accQ.pop_front() : 'x, exp);
   endtask : cmpAcc
   // one write burst, one strobe change per beat, data set well before it
   task automatic wrBurst(input logic [2:0] ba, input logic [12:0] a, input int n,
                          input logic il);
      logic [7:0] d;
      ctl_u.send(1'b0, 3'h4, ba, a);
      for (int i = 0; i < n; i++)
      begin
         seed = lfsr(seed);
         d = seed[7:0];
         @(posedge clock);
         dqIn <= d;
         repeat (4) @(posedge clock);
         dqsIn <= ~dqsIn;
         dqsNIn <= ~dqsNIn;
         repeat (6) @(posedge clock);
         cmpAcc({1'b1, ba, rows[ba], colOf(a[9:0], i, il, n == 4), d});
         @(posedge clock);
         dqIn <= ~d;
      end
   endtask : wrBurst
   task automatic results();
      if (mismatches == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results
   // ****************
   // scenarios
   // ****************
   initial
   begin
      {dqIn, arrayRdData, dqsIn, dqsNIn, extTemp} = 19'h00002;
      expOpen = '0;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      cmpVec({dqOe_r, clockHalted_r, bankOpen_r}, 10'h100);
      ctl_u.gate(1'b1);
      ctl_u.send(1'b1, 3'h3, 3'h3, 13'h0000);
      cmpVec(bankOpen_r, expOpen);
      for (int b = 0; b < NUM_BANKS; b++)
      begin
         seed = lfsr(seed);
         rows[b] = seed[12:0];
         ctl_u.send(1'b0, 3'h3, 3'(b), rows[b]);
         expOpen[b] = 1'b1;
         cmpVec(bankOpen_r, expOpen);
      end
      ctl_u.send(1'b0, 3'h2, 3'h5, 13'h0000);
      expOpen[5] = 1'b0;
      cmpVec(bankOpen_r, expOpen);
      // fixed eight, chopped interleaved, chopped sequential with auto-precharge
      for (int m = 0; m < 3; m++)
      begin
         ctl_u.send(1'b0, 3'h0, 3'h0, m == 0 ? 13'h0000 : m == 1 ? 13'h0009 : 13'h0001);
         accQ.delete();
         seed = lfsr(seed);
         wrBurst(3'(m + 2), {m == 0, 1'b0, m == 2, seed[9:0]}, m == 0 ? 8 : 4, m == 1);
      end
      repeat (4) @(posedge clock);
      expOpen[4] = 1'b0;
      cmpVec(bankOpen_r, expOpen);
      // additive latency of read latency less one: seven crossings in all
      ctl_u.send(1'b0, 3'h0, 3'h1, 13'h0008);
      seed = lfsr(seed);
      arrayRdData <= seed[7:0];
      accQ.delete();
      ctl_u.send(1'b0, 3'h5, 3'h2, {3'h4, seed[17:8]});
      for (waited = 0; waited < 80 && dqOe_r !== 1'b1; waited++)
         @(posedge clock);
      // send returns seven clocks after its crossing, the beat shows three after its own
      cmpVec(waited, 8 * (4 + 3) - 4);
      cmpVec({dqOe_r, dqOut_r}, {1'b1, seed[7:0]});
      cmpVec(accQ.size() > 0 ? accQ[0][34:8] : 'x, {4'h2, rows[2], seed[17:8]});
      for (int t = 0; t < 80 && dqOe_r !== 1'b0; t++)
         @(posedge clock);
      ctl_u.send(1'b0, 3'h2, 3'h0, 13'h0400);
      cmpVec(bankOpen_r, 8'h00);
      ctl_u.refresh();
      repeat (200) @(posedge clock);
      cmpVec(refreshLate_r, 1'b0);
      extTemp <= 1'b1;
      repeat (40) @(posedge clock);
      cmpVec(refreshLate_r, 1'b1);
      ctl_u.refresh();
      cmpVec(refreshLate_r, 1'b0);
      ctl_u.gate(1'b0);
      repeat (16) @(posedge clock);
      cmpVec({powerDown_r, selfRefresh_r, clockHalted_r}, 3'h5);
      ctl_u.send(1'b0, 3'h3, 3'h1, 13'h0000);
      cmpVec(bankOpen_r, 8'h00);
      ctl_u.gate(1'b1);
      cmpVec({powerDown_r, clockHalted_r}, 2'h0);
      // gate dropped on the very crossing that carries a refresh
      fork
         ctl_u.gate(1'b0);
         ctl_u.refresh();
      join
      cmpVec({powerDown_r, selfRefresh_r, clockHalted_r}, 3'h3);
      results();
   end
   // hang guard, far beyond the thousand or so cycles the scenarios need
   initial
   begin
      repeat (20000) @(posedge clock);
      mismatches++;
      results();
   end
endmodule : tb_sdram_command_address_port
